// *** logic/pteu_top.sv ***
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pteu_top import pteu_pkg::*; #(
    parameter int NUM_CH = PTEU_CHANNELS,
    parameter int NUM_PADS = PTEU_PADS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_PADS-1:0] gpio_out_val,
    input wire logic [NUM_PADS-1:0] gpio_dir_out,
    input wire logic [NUM_PADS-1:0] pad_in,
    output logic [NUM_PADS-1:0] pad_out,
    output logic [NUM_PADS-1:0] pad_oe,
    input wire logic combined_level_flag,
    input wire logic off_state,
    output logic off_wake,
    input wire logic [PTEU_FABRIC_CH-1:0] fabric_task_in,
    output logic [PTEU_FABRIC_CH-1:0] fabric_event_out,
    output logic irq
);

    // ==========================================================
    // Elaboration checks
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
        $error("NUM_CH must be 1 to 8");
    end
    if (NUM_PADS < 1 || NUM_PADS > 32) begin : g_bad_pads
        $error("NUM_PADS must be 1 to 32");
    end

    // ==========================================================
    // Bus decode
    wire logic wr_en = psel & penable & pwrite;
    wire logic rd_setup = psel & ~penable & ~pwrite;
    wire logic [31:0] pad_in_ext = 32'(pad_in);

    wire logic hit_ev_port = paddr == OFF_EV_PORT;
    wire logic hit_pub_port = paddr == OFF_PUB_PORT;
    wire logic hit_raise = paddr == OFF_IRQ_RAISE;
    wire logic hit_drop = paddr == OFF_IRQ_DROP;

    logic [NUM_CH-1:0] ch_hit;
    logic [NUM_CH-1:0] ch_ev;
    logic [NUM_CH-1:0] ev_flag_reg;
    logic [31:0] rd_part [NUM_CH];
    pteu_setup_t setup_reg [NUM_CH];
    logic [NUM_CH-1:0] level_reg;
    pteu_link_t pub_ch_reg [NUM_CH];

    pteu_link_t pub_port_reg;
    logic port_flag_reg;
    logic detect_prev_reg;
    logic [31:0] irq_en_reg;
    logic [31:0] prdata_reg;
    logic [PTEU_FABRIC_CH-1:0] fabric_ev_reg;
    logic [PTEU_FABRIC_CH-1:0] fabric_ev_next;
    logic off_wake_reg;
    logic [31:0] rd_word;

    wire logic [31:0] irq_mask = {1'b1, 31'(1'b0)} | 32'({NUM_CH{1'b1}});

    // ==========================================================
    // Channels
    // R1 eight channels
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam logic [11:0] STEP = 12'(i * 4);
        wire logic h_tcfg = paddr == OFF_TASK_CFG + STEP;
        wire logic h_thigh = paddr == OFF_TASK_HIGH + STEP;
        wire logic h_tlow = paddr == OFF_TASK_LOW + STEP;
        wire logic h_scfg = paddr == OFF_SUB_CFG + STEP;
        wire logic h_shigh = paddr == OFF_SUB_HIGH + STEP;
        wire logic h_slow = paddr == OFF_SUB_LOW + STEP;
        wire logic h_ev = paddr == OFF_EV_CH + STEP;
        wire logic h_pub = paddr == OFF_PUB_CH + STEP;
        wire logic h_setup = paddr == OFF_SETUP + STEP;

        pteu_link_t sub_cfg_reg;
        pteu_link_t sub_high_reg;
        pteu_link_t sub_low_reg;
        logic prev_reg;
        logic armed_reg;
        logic lvl_next;
        pteu_setup_t setup_next;

        assign ch_hit[i] = h_tcfg | h_thigh | h_tlow | h_scfg | h_shigh
            | h_slow | h_ev | h_pub | h_setup;

        // R21 configurable trigger
        wire logic t_cfg = (wr_en & h_tcfg & pwdata[0])
            | (sub_cfg_reg.en & fabric_task_in[sub_cfg_reg.idx]);
        wire logic t_high = (wr_en & h_thigh & pwdata[0])
            | (sub_high_reg.en & fabric_task_in[sub_high_reg.idx]);
        wire logic t_low = (wr_en & h_tlow & pwdata[0])
            | (sub_low_reg.en & fabric_task_in[sub_low_reg.idx]);

        wire logic in_task = setup_reg[i].mode == MODE_TASK;
        wire logic in_event = setup_reg[i].mode == MODE_EVENT;
        wire logic setup_wr = wr_en & h_setup;
        wire logic [1:0] new_mode = pwdata[SETUP_MODE_LSB +: 2];
        wire logic enter_task = setup_wr & new_mode == MODE_TASK & ~in_task;

        // R2 selected pad input
        wire logic pin = pad_in_ext[setup_reg[i].pad_sel];
        wire logic rise = pin & ~prev_reg;
        wire logic fall = ~pin & prev_reg;

        // R5 edge choice
        assign ch_ev[i] = armed_reg & in_event & (
            (setup_reg[i].action == ACT_SET & rise)
            | (setup_reg[i].action == ACT_CLEAR & fall)
            | (setup_reg[i].action == ACT_TOGGLE & (rise | fall)));

        always_comb begin
            setup_next = setup_reg[i];
            setup_next.mode = new_mode;
            setup_next.action = pwdata[SETUP_ACT_LSB +: 2];
            setup_next.init = pwdata[SETUP_INIT_BIT];
            // R19 pad locked unless disabled
            if (setup_reg[i].mode == MODE_OFF) begin
                setup_next.pad_sel = pwdata[SETUP_PAD_LSB +: 5];
            end
        end

        always_comb begin
            lvl_next = level_reg[i];
            if (enter_task) begin
                // R10 initial level
                lvl_next = setup_next.init;
            end else if (in_task) begin
                // R8 priority order
                if (t_cfg) begin
                    // R4 R9 configurable action
                    unique case (setup_reg[i].action)
                        ACT_SET: lvl_next = 1'b1;
                        ACT_CLEAR: lvl_next = 1'b0;
                        ACT_TOGGLE: lvl_next = ~level_reg[i];
                        ACT_NONE: lvl_next = level_reg[i];
                    endcase
                end else if (t_low) begin
                    // R3 drive low
                    lvl_next = 1'b0;
                end else if (t_high) begin
                    // R3 drive high
                    lvl_next = 1'b1;
                end
            end
        end

        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                setup_reg[i] <= SETUP_RESET;
                sub_cfg_reg <= LINK_RESET;
                sub_high_reg <= LINK_RESET;
                sub_low_reg <= LINK_RESET;
                pub_ch_reg[i] <= LINK_RESET;
                level_reg[i] <= 1'b0;
                prev_reg <= 1'b0;
                armed_reg <= 1'b0;
            end else begin
                if (setup_wr) begin
                    setup_reg[i] <= setup_next;
                end
                if (wr_en & h_scfg) begin
                    sub_cfg_reg <= word_link(pwdata);
                end
                if (wr_en & h_shigh) begin
                    sub_high_reg <= word_link(pwdata);
                end
                if (wr_en & h_slow) begin
                    sub_low_reg <= word_link(pwdata);
                end
                if (wr_en & h_pub) begin
                    pub_ch_reg[i] <= word_link(pwdata);
                end
                level_reg[i] <= lvl_next;
                prev_reg <= pin;
                // R22 arm one cycle after pad settles
                armed_reg <= in_event & ~setup_wr;
            end
        end

        // R23 sticky flag, set wins
        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                ev_flag_reg[i] <= 1'b0;
            end else begin
                ev_flag_reg[i] <= ch_ev[i]
                    | (wr_en & h_ev ? pwdata[0] : ev_flag_reg[i]);
            end
        end

        assign rd_part[i] = (h_scfg ? link_word(sub_cfg_reg) : 32'h0)
            | (h_shigh ? link_word(sub_high_reg) : 32'h0)
            | (h_slow ? link_word(sub_low_reg) : 32'h0)
            | (h_pub ? link_word(pub_ch_reg[i]) : 32'h0)
            | (h_ev ? 32'(ev_flag_reg[i]) : 32'h0)
            | (h_setup ? setup_word(setup_reg[i]) : 32'h0);
    end

    // ==========================================================
    // Pad override
    always_comb begin
        for (int p = 0; p < NUM_PADS; p++) begin
            // R7 R18 default to ordinary GPIO
            pad_out[p] = gpio_out_val[p];
            pad_oe[p] = gpio_dir_out[p];
            for (int c = 0; c < NUM_CH; c++) begin
                if (setup_reg[c].mode != MODE_OFF
                    && 32'(setup_reg[c].pad_sel) == p) begin
                    // R6 unit owns the output
                    pad_out[p] = level_reg[c];
                    // R16 R17 direction override
                    pad_oe[p] = setup_reg[c].mode == MODE_TASK;
                end
            end
        end
    end

    // ==========================================================
    // Port event
    // R11 R12 rising edge of combined flag
    wire logic port_ev = combined_level_flag & ~detect_prev_reg;

    always_comb begin
        fabric_ev_next = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (ch_ev[c] & pub_ch_reg[c].en) begin
                fabric_ev_next[pub_ch_reg[c].idx] = 1'b1;
            end
        end
        if (port_ev & pub_port_reg.en) begin
            fabric_ev_next[pub_port_reg.idx] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            detect_prev_reg <= 1'b0;
            port_flag_reg <= 1'b0;
            pub_port_reg <= LINK_RESET;
            fabric_ev_reg <= '0;
            off_wake_reg <= 1'b0;
        end else begin
            detect_prev_reg <= combined_level_flag;
            // R23 port flag, set wins
            port_flag_reg <= port_ev
                | (wr_en & hit_ev_port ? pwdata[0] : port_flag_reg);
            if (wr_en & hit_pub_port) begin
                pub_port_reg <= word_link(pwdata);
            end
            fabric_ev_reg <= fabric_ev_next;
            // R13 wake from off state
            off_wake_reg <= off_state & combined_level_flag;
        end
    end

    // ==========================================================
    // Interrupt enables and read data
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_en_reg <= RESET_WORD;
            prdata_reg <= RESET_WORD;
        end else begin
            if (wr_en & hit_raise) begin
                irq_en_reg <= (irq_en_reg | pwdata) & irq_mask;
            end else if (wr_en & hit_drop) begin
                irq_en_reg <= irq_en_reg & ~pwdata;
            end
            if (rd_setup) begin
                prdata_reg <= rd_word;
            end
        end
    end

    always_comb begin
        rd_word = (hit_ev_port ? 32'(port_flag_reg) : 32'h0)
            | (hit_pub_port ? link_word(pub_port_reg) : 32'h0)
            | (hit_raise | hit_drop ? irq_en_reg : 32'h0);
        for (int c = 0; c < NUM_CH; c++) begin
            rd_word = rd_word | rd_part[c];
        end
    end

    wire logic any_hit = |ch_hit | hit_ev_port | hit_pub_port | hit_raise
        | hit_drop;

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~any_hit;
    assign fabric_event_out = fabric_ev_reg;
    assign off_wake = off_wake_reg;
    // R23 interrupt request
    assign irq = |(ev_flag_reg & irq_en_reg[NUM_CH-1:0])
        | (port_flag_reg & irq_en_reg[IRQ_PORT_BIT]);

endmodule
`default_nettype wire

// *** logic/pteu_pkg.sv ***
// What this block does
// R1 - Eight channels, each with high, low and configurable tasks plus one event.
// R2 - Each channel acts on one pad, picked by its pad_select field.
// R3 - High task drives the pad to one, low task drives it to zero.
// R4 - Configurable task sets, clears or toggles per task_action_field; none does nothing.
// R5 - Event mode flags rising, falling or any change of the selected pad.
// R6 - A controlled pad ignores the ordinary GPIO output value.
// R7 - A released pad returns to ordinary GPIO value and direction.
// R8 - Same-cycle tasks: configurable wins, then low, then high.
// R9 - Configurable task with none action still wins and leaves pad unchanged.
// R10 - Entering task mode drives the pad to initial_level_field.
// R11 - Port event fires on each rising edge of combined_level_flag.
// R12 - A held flag left set after clearing yields no fresh rising edge.
// R13 - Off state entered with combined_level_flag high wakes at once.
// R14 - Software clears all combined-flag sources before idling.
// R15 - Software disables irq, sets sense, clears port flag, re-enables irq.
// R16 - Event mode makes the selected pad an input.
// R17 - Task mode makes the selected pad an output with this unit's level.
// R18 - Disabled mode leaves the pad to its gpio_pad_setup.
// R19 - Pad_select changes only while the channel is disabled.
// R20 - Software never gives one pad to two channels.
// R21 - Configurable trigger at 0x000 plus four per channel; writing 1 fires.
// R22 - Pad change detection works in both on and off states.
// R23 - Event flags stick until written zero; enabled set flags request irq.
package pteu_pkg;
    localparam int PTEU_CHANNELS = 8;
    localparam int PTEU_PADS = 32;
    localparam int PTEU_FABRIC_CH = 256;

    localparam logic [11:0] OFF_TASK_CFG = 12'h000;
    localparam logic [11:0] OFF_TASK_HIGH = 12'h030;
    localparam logic [11:0] OFF_TASK_LOW = 12'h060;
    localparam logic [11:0] OFF_SUB_CFG = 12'h080;
    localparam logic [11:0] OFF_SUB_HIGH = 12'h0b0;
    localparam logic [11:0] OFF_SUB_LOW = 12'h0e0;
    localparam logic [11:0] OFF_EV_CH = 12'h100;
    localparam logic [11:0] OFF_EV_PORT = 12'h17c;
    localparam logic [11:0] OFF_PUB_CH = 12'h180;
    localparam logic [11:0] OFF_PUB_PORT = 12'h1fc;
    localparam logic [11:0] OFF_IRQ_RAISE = 12'h304;
    localparam logic [11:0] OFF_IRQ_DROP = 12'h308;
    localparam logic [11:0] OFF_SETUP = 12'h510;
    localparam logic [11:0] REG_STRIDE = 12'h004;

    // Link word: fabric channel index and enable
    localparam int LINK_IDX_LSB = 0;
    localparam int LINK_EN_BIT = 31;
    // Setup word
    localparam int SETUP_MODE_LSB = 0;
    localparam int SETUP_PAD_LSB = 8;
    localparam int SETUP_ACT_LSB = 16;
    localparam int SETUP_INIT_BIT = 20;
    localparam int IRQ_PORT_BIT = 31;

    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TASK = 2'h3;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_SET = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam logic [31:0] RESET_WORD = 32'h0;

    typedef struct packed {
        logic init;
        logic [1:0] action;
        logic [4:0] pad_sel;
        logic [1:0] mode;
    } pteu_setup_t;

    typedef struct packed {
        logic en;
        logic [7:0] idx;
    } pteu_link_t;

    localparam pteu_setup_t SETUP_RESET = '0;
    localparam pteu_link_t LINK_RESET = '0;

    function automatic logic [31:0] link_word(input pteu_link_t l);
        logic [31:0] w;
        w = 32'h0;
        w[LINK_IDX_LSB +: 8] = l.idx;
        w[LINK_EN_BIT] = l.en;
        return w;
    endfunction

    function automatic pteu_link_t word_link(input logic [31:0] w);
        pteu_link_t l;
        l.idx = w[LINK_IDX_LSB +: 8];
        l.en = w[LINK_EN_BIT];
        return l;
    endfunction

    function automatic logic [31:0] setup_word(input pteu_setup_t s);
        logic [31:0] w;
        w = 32'h0;
        w[SETUP_MODE_LSB +: 2] = s.mode;
        w[SETUP_PAD_LSB +: 5] = s.pad_sel;
        w[SETUP_ACT_LSB +: 2] = s.action;
        w[SETUP_INIT_BIT] = s.init;
        return w;
    endfunction
endpackage

// *** tb/pteu_pad_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Pad ring
module pteu_pad_model #(
    parameter int NUM_PADS = 32
) (
    input wire logic [NUM_PADS-1:0] pad_out,
    input wire logic [NUM_PADS-1:0] pad_oe,
    input wire logic [NUM_PADS-1:0] ext_level,
    output logic [NUM_PADS-1:0] pad_in
);
    // Driven pads read back, others follow outside level
    assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule
`default_nettype wire

// *** tb/pteu_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module pteu_monitor import pteu_pkg::*; #(
    parameter int NUM_CH = PTEU_CHANNELS,
    parameter int NUM_PADS = PTEU_PADS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_PADS-1:0] gpio_out_val,
    input wire logic [NUM_PADS-1:0] gpio_dir_out,
    input wire logic [NUM_PADS-1:0] pad_out,
    input wire logic [NUM_PADS-1:0] pad_oe,
    input wire logic combined_level_flag,
    input wire logic off_state,
    input wire logic off_wake
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    wire setup_hit = paddr >= OFF_SETUP
        && paddr < OFF_SETUP + 12'(4 * NUM_CH);
    wire [1:0] mode_w = pwdata[SETUP_MODE_LSB +: 2];
    wire [4:0] pad_w = pwdata[SETUP_PAD_LSB +: 5];
    wire init_w = pwdata[SETUP_INIT_BIT];

    // ==========
    // Mode and pad per channel as written, pad locked unless off
    logic [1:0] mode_reg [NUM_CH];
    logic [4:0] pad_reg [NUM_CH];
    wire [2:0] ch_w = 3'((paddr - OFF_SETUP) >> 2);
    wire [4:0] pad_k = mode_reg[ch_w] == MODE_OFF ? pad_w : pad_reg[ch_w];
    wire was_task = mode_reg[ch_w] == MODE_TASK;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < NUM_CH; c++) begin
                mode_reg[c] <= MODE_OFF;
                pad_reg[c] <= 5'h0;
            end
        end else if (psel && penable && pwrite && setup_hit) begin
            mode_reg[ch_w] <= mode_w;
            pad_reg[ch_w] <= pad_k;
        end
    end

    // ==========
    // Properties
    sequence s_setup_wr;
        psel && !penable ##1 psel && penable && pwrite && setup_hit;
    endsequence
    property p_task_init;
        s_setup_wr ##0 (mode_w == MODE_TASK && !was_task) |=>
            pad_oe[$past(pad_k)]
            && pad_out[$past(pad_k)] == $past(init_w);
    endproperty
    property p_event_in;
        s_setup_wr ##0 mode_w == MODE_EVENT |=> !pad_oe[$past(pad_k)];
    endproperty
    property p_off_dir;
        s_setup_wr ##0 mode_w == MODE_OFF |=>
            pad_oe[$past(pad_k)] == gpio_dir_out[$past(pad_k)];
    endproperty
    property p_off_val;
        s_setup_wr ##0 mode_w == MODE_OFF |=>
            pad_out[$past(pad_k)] == gpio_out_val[$past(pad_k)];
    endproperty
    property p_ready;
        psel && penable |-> pready;
    endproperty
    property p_err;
        pslverr |-> psel && penable && !setup_hit;
    endproperty
    property p_wake;
        off_state && combined_level_flag |=> off_wake;
    endproperty
    property p_wake_hold;
        !off_state |=> !off_wake;
    endproperty

    a_task_init: assert property (p_task_init)
        else $error("task entry level wrong");
    a_event_in: assert property (p_event_in)
        else $error("event pad still driven");
    a_off_dir: assert property (p_off_dir)
        else $error("released pad direction wrong");
    a_off_val: assert property (p_off_val)
        else $error("released pad value wrong");
    a_ready: assert property (p_ready)
        else $error("access not ready");
    a_err: assert property (p_err)
        else $error("error on mapped access");
    a_wake: assert property (p_wake)
        else $error("off wake missing");
    a_wake_hold: assert property (p_wake_hold)
        else $error("off wake outside off state");
endmodule

bind pteu_top pteu_monitor #(
    .NUM_CH(NUM_CH), .NUM_PADS(NUM_PADS)
) pteu_monitor_i (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .gpio_out_val(gpio_out_val),
    .gpio_dir_out(gpio_dir_out), .pad_out(pad_out), .pad_oe(pad_oe),
    .combined_level_flag(combined_level_flag), .off_state(off_state),
    .off_wake(off_wake)
);
`default_nettype wire

// *** tb/pin_task_event_unit_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_task_event_unit_test import pteu_pkg::*;;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic combined_level_flag, off_state, off_wake, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, gpio_out_val, gpio_dir_out;
    logic [31:0] pad_in, pad_out, pad_oe, ext_level;
    logic [255:0] fabric_task_in, fabric_event_out;
    int mismatches = 0;
    int tests_run = 0;

    pteu_top pteu_top_i (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_out_val(gpio_out_val),
        .gpio_dir_out(gpio_dir_out), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .combined_level_flag(combined_level_flag),
        .off_state(off_state), .off_wake(off_wake),
        .fabric_task_in(fabric_task_in),
        .fabric_event_out(fabric_event_out), .irq(irq)
    );
    pteu_pad_model pteu_pad_model_i (
        .pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
        .pad_in(pad_in)
    );

    // ==========
    // Helpers
    function automatic logic [11:0] ra(input logic [11:0] b, input int c);
        return b + 12'(4 * c);
    endfunction
    function automatic logic [31:0] cfg(input logic [1:0] m, a,
        input logic [4:0] p, input logic i);
        return {11'h0, i, 2'h0, a, 3'h0, p, 6'h0, m};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic setw(input int c, input logic [31:0] w);
        apb(1'b1, ra(OFF_SETUP, c), w);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic sub(input logic c, l, h);
        apb(1'b1, ra(OFF_SUB_CFG, 1), {c, 23'h0, 8'h07});
        apb(1'b1, ra(OFF_SUB_LOW, 1), {l, 23'h0, 8'h07});
        apb(1'b1, ra(OFF_SUB_HIGH, 1), {h, 23'h0, 8'h07});
        fabric_task_in[7] <= 1'b1;
        @(posedge ref_clk);
        fabric_task_in[7] <= 1'b0;
        cyc(2);
    endtask

    // ==========
    // Scenarios
    task automatic t_reset;
        apb(1'b0, ra(OFF_SETUP, 3), 32'h0);
        chk("setup reset", RESET_WORD, rd);
        chk("idle out", gpio_out_val, pad_out);
        chk("idle oe", gpio_dir_out, pad_oe);
        apb(1'b0, 12'h400, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        $display("reset test done");
    endtask
    task automatic t_tasks;
        logic [1:0] a;
        gpio_out_val[5] <= 1'b1;
        setw(7, cfg(MODE_TASK, ACT_NONE, 5'h05, 1'b0));
        chk("init level", 32'h0, pad_out[5]);
        chk("task oe", 32'h1, pad_oe[5]);
        apb(1'b1, ra(OFF_TASK_HIGH, 7), 32'h1);
        chk("high task", 32'h1, pad_out[5]);
        apb(1'b1, ra(OFF_TASK_LOW, 7), 32'h1);
        chk("low task", 32'h0, pad_out[5]);
        setw(7, cfg(MODE_OFF, ACT_NONE, 5'h09, 1'b0));
        chk("release out", 32'h1, pad_out[5]);
        chk("release oe", 32'h0, pad_oe[5]);
        apb(1'b0, ra(OFF_SETUP, 7), 32'h0);
        chk("pad locked", cfg(MODE_OFF, ACT_NONE, 5'h05, 1'b0), rd);
        for (int i = 0; i < 4; i++) begin
            a = 2'(i);
            setw(7, cfg(MODE_TASK, a, 5'h05, a == ACT_CLEAR));
            apb(1'b1, ra(OFF_TASK_CFG, 7), 32'h1);
            chk("cfg task", 32'(a[0]), pad_out[5]);
            setw(7, cfg(MODE_OFF, ACT_NONE, 5'h05, 1'b0));
        end
        $display("task test done");
    endtask
    task automatic t_prio;
        setw(1, cfg(MODE_TASK, ACT_TOGGLE, 5'h06, 1'b0));
        sub(1'b1, 1'b1, 1'b1);
        chk("cfg first", 32'h1, pad_out[6]);
        sub(1'b0, 1'b1, 1'b1);
        chk("low second", 32'h0, pad_out[6]);
        setw(1, cfg(MODE_OFF, ACT_NONE, 5'h06, 1'b0));
        setw(1, cfg(MODE_TASK, ACT_NONE, 5'h06, 1'b1));
        sub(1'b1, 1'b1, 1'b1);
        chk("none wins", 32'h1, pad_out[6]);
        $display("priority test done");
    endtask
    task automatic t_events;
        logic [1:0] a;
        apb(1'b1, OFF_IRQ_RAISE, 32'h1);
        apb(1'b1, ra(OFF_PUB_CH, 0), {1'b1, 23'h0, 8'h09});
        for (int i = 1; i < 4; i++) begin
            a = 2'(i);
            setw(0, cfg(MODE_EVENT, a, 5'h03, 1'b0));
            chk("event oe", 32'h0, pad_oe[3]);
            ext_level[3] <= 1'b1;
            repeat (2) @(negedge ref_clk);
            chk("publish", 32'(a != ACT_CLEAR), fabric_event_out[9]);
            @(negedge ref_clk);
            chk("publish end", 32'h0, fabric_event_out[9]);
            cyc(2);
            chk("rise irq", 32'(a != ACT_CLEAR), irq);
            apb(1'b0, ra(OFF_EV_CH, 0), 32'h0);
            chk("rise flag", 32'(a != ACT_CLEAR), rd);
            apb(1'b1, ra(OFF_EV_CH, 0), 32'h0);
            chk("flag clear irq", 32'h0, irq);
            ext_level[3] <= 1'b0;
            cyc(4);
            apb(1'b0, ra(OFF_EV_CH, 0), 32'h0);
            chk("fall flag", 32'(a != ACT_SET), rd);
            apb(1'b1, ra(OFF_EV_CH, 0), 32'h0);
        end
        setw(0, cfg(MODE_OFF, ACT_NONE, 5'h03, 1'b0));
        $display("event test done");
    endtask
    task automatic t_port;
        apb(1'b1, OFF_IRQ_DROP, 32'h8000_0001);
        combined_level_flag <= 1'b1;
        cyc(3);
        apb(1'b0, OFF_EV_PORT, 32'h0);
        chk("port flag", 32'h1, rd);
        chk("port masked", 32'h0, irq);
        off_state <= 1'b1;
        cyc(3);
        chk("off wake", 32'h1, off_wake);
        off_state <= 1'b0;
        combined_level_flag <= 1'b0;
        apb(1'b1, OFF_EV_PORT, 32'h0);
        apb(1'b1, OFF_IRQ_RAISE, 32'h8000_0000);
        chk("port cleared", 32'h0, irq);
        combined_level_flag <= 1'b1;
        cyc(3);
        chk("port irq", 32'h1, irq);
        apb(1'b1, OFF_EV_PORT, 32'h0);
        chk("level no event", 32'h0, irq);
        combined_level_flag <= 1'b0;
        $display("port test done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (4000) @(posedge ref_clk);
        mismatches++;
        finish_test;
    end
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, off_state, combined_level_flag} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        gpio_out_val = 32'h0000_00a0;
        gpio_dir_out = 32'h0000_0008;
        ext_level = 32'h0;
        fabric_task_in = '0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        // channels 7, 1, 0 on pads 5, 6, 3
        t_reset;
        t_tasks;
        t_prio;
        t_events;
        t_port;
        finish_test;
    end
endmodule
`default_nettype wire
